// ### src/bridge_err_map.svh
// Configuration offsets, field positions, reset values and counts for the bridge error block
`ifndef BRIDGE_ERR_MAP_SVH
`define BRIDGE_ERR_MAP_SVH

// =============================================
// Configuration offsets (byte addresses)
`define OFF_COMMAND        8'h04
`define OFF_STATUS         8'h06
`define OFF_BRIDGE_CONTROL 8'h3E
`define OFF_SERR_CONTROL   8'h60
`define OFF_SERR_STATUS    8'h61
`define OFF_DIAG_CONTROL   8'h70

// =============================================
// Command register fields
`define CMD_PERR_RESP      6
`define CMD_SERR_EN        8
// Status register fields
`define STS_DATA_PERR      8
`define STS_SIG_SERR       14
`define STS_DET_PERR       15
// Bridge control fields
`define BRC_SERR_FWD       1
`define BRC_MABORT_MODE    5
// Diagnostic control fields
`define DIAG_DISCARD_LONG  1
`define DIAG_PARITY_FIX    14
`define DIAG_RETRY_TO_EN   15
// System-error status bit positions
`define SERR_DISCARD_NP    4
`define SERR_ADDR_PERR     6
`define SERR_RETRY_TO      7

// =============================================
// Reset values
`define RST_COMMAND        16'h0000
`define RST_BRIDGE_CONTROL 16'h0000
`define RST_SERR_CONTROL   8'h00
`define RST_DIAG_CONTROL   16'h0002

// =============================================
// Discard limits in PCI clocks
`define DISCARD_LONG_CLKS  32768
`define DISCARD_SHORT_CLKS 1024

`endif

// ### src/bridge_err_pkg.sv
// Types shared by the bridge error block
package bridge_err_pkg;

	// =============================================
	// Discard timer states
	typedef enum logic [0:0] {
		DT_IDLE  = 1'b0,
		DT_ARMED = 1'b1
	} dt_state_t;

endpackage : bridge_err_pkg

// ### src/discard_timer.sv
// Delayed-completion discard timer
`timescale 1ns/100ps
`default_nettype none
module discard_timer #(
	parameter int LONG_CLKS  = 32768,
	parameter int SHORT_CLKS = 1024
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic start,
	input  wire logic nonpref,
	input  wire logic retry_match,
	input  wire logic long_sel,
	output logic      pending,
	output logic      expire,
	output logic      expire_np
);
	localparam int CW = $clog2(LONG_CLKS + 1);

	// =============================================
	// Parameter check
	if (SHORT_CLKS < 1 || SHORT_CLKS > LONG_CLKS) begin : g_bad_limits
		$error("discard_timer: limits out of range");
	end

	bridge_err_pkg::dt_state_t state_reg, state_next;
	logic [CW-1:0]             cnt_reg, cnt_next;
	logic                      np_reg, np_next;
	logic                      exp_reg, exp_next;
	logic                      limit_hit;
	logic [CW-1:0]             limit;

	// Limit picked live, so a mode change applies to a running count
	assign limit     = long_sel ? CW'(LONG_CLKS) : CW'(SHORT_CLKS);
	assign limit_hit = (cnt_reg >= limit - CW'(1));

	// Next-state logic: arm on completion, stop on matched retry, drop on expiry
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		np_next    = np_reg;
		exp_next   = 1'b0;
		case (state_reg)
			bridge_err_pkg::DT_IDLE: begin
				if (start) begin // RL14
					state_next = bridge_err_pkg::DT_ARMED;
					cnt_next   = '0;
					np_next    = nonpref;
				end
			end
			bridge_err_pkg::DT_ARMED: begin
				if (retry_match) begin // RL20
					state_next = bridge_err_pkg::DT_IDLE;
					cnt_next   = '0;
				end else if (limit_hit) begin // RL17
					state_next = bridge_err_pkg::DT_IDLE;
					cnt_next   = '0;
					exp_next   = 1'b1;
				end else begin
					cnt_next = cnt_reg + CW'(1);
				end
			end
			default: begin
				state_next = bridge_err_pkg::DT_IDLE;
				cnt_next   = '0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= bridge_err_pkg::DT_IDLE;
			cnt_reg   <= '0;
			np_reg    <= 1'b0;
			exp_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			np_reg    <= np_next;
			exp_reg   <= exp_next;
		end
	end

	assign pending   = (state_reg == bridge_err_pkg::DT_ARMED);
	assign expire    = exp_reg;
	assign expire_np = exp_reg & np_reg;

endmodule : discard_timer
`default_nettype wire

// ### src/bridge_error_reporting.sv
// Bridge error detection, system-error reporting and delayed-completion discard
// Operation
// RL1 - Mastering parity error with control bit 5 raises system error, sets W1C status bit 5.
// RL2 - Software should enable mastering-parity reporting only while fixing parity.
// RL3 - Parity response on: address parity or target abort raises system error, status bit 6.
// RL4 - Retry timeout enabled by diagnostic bit 15: expiry raises system error, status bit 7.
// RL5 - Secondary system error forwarded only when command bit 8 and bridge control bit 1 set.
// RL6 - Diagnostic bit 14 clear passes parity errors; set regenerates parity.
// RL7 - Use parity passing only when system devices can recover from errors.
// RL8 - Parity response on: bad received data asserts PERR.
// RL9 - Any detected bad parity sets status bit 15.
// RL10 - Parity response on: bad parity, or PERR driven or seen as master, sets bit 8.
// RL11 - Target abort on forwarded write returns target abort to initiator.
// RL12 - Target abort on forwarded read delivers valid data then disconnects.
// RL13 - Primary access during secondary reset follows master abort mode bit 5.
// RL14 - After delayed completion, count clocks and discard if master does not retry.
// RL15 - Discard limit defaults to 2^15 clocks; diagnostic bit 1 clear gives 2^10.
// RL16 - Prefetchable completed delayed reads may also be discarded.
// RL17 - On discard timer expiry, drop pending completion data and status.
// RL18 - Control-gated conditions also need command bit 8; bit 14 set on any system error.
// RL19 - Control bit 4 and expiry on nonprefetchable read raise system error, status bit 4.
// RL20 - Matching retry with delivery stops and clears the discard timer.
`include "bridge_err_map.svh"
`timescale 1ns/100ps
`default_nettype none
module bridge_error_reporting #(
	parameter int DISCARD_LONG_CLKS  = `DISCARD_LONG_CLKS,
	parameter int DISCARD_SHORT_CLKS = `DISCARD_SHORT_CLKS
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	input  wire logic        arb_timeout,
	input  wire logic        posted_perr,
	input  wire logic        posted_tabort,
	input  wire logic        posted_mabort,
	input  wire logic        par_err_master,
	input  wire logic        addr_par_err,
	input  wire logic        data_par_err,
	input  wire logic        perr_seen_master,
	input  wire logic        tgt_abort_rx,
	input  wire logic        burst_is_write,
	input  wire logic        retry_expired,
	input  wire logic        sec_serr_n,
	input  wire logic        prim_txn_sec_rst,
	input  wire logic        dt_complete,
	input  wire logic        dt_prefetch,
	input  wire logic        dt_retry_match,
	output logic             serr_out,
	output logic             serr_oe,
	output logic             perr_out,
	output logic             perr_oe,
	output logic             parity_fix,
	output logic             init_tgt_abort,
	output logic             init_disconnect,
	output logic             sec_rst_tabort,
	output logic             dt_pending,
	output logic             dt_discard
);

	// =============================================
	// Parameter check
	// Refused at elaboration: an empty or inverted pair of limits leaves the timer no short mode
	if (DISCARD_SHORT_CLKS < 1 || DISCARD_SHORT_CLKS > DISCARD_LONG_CLKS) begin : g_bad_limits
		$error("bridge_error_reporting: discard limits out of range");
	end

	// =============================================
	// Registers
	logic [15:0] command_reg;
	logic [15:0] status_reg, status_next;
	logic [15:0] bridge_control_reg;
	logic [7:0]  serr_control_reg;
	logic [7:0]  serr_status_reg, serr_status_next;
	logic [15:0] diag_control_reg;
	logic [15:0] rdata_reg;
	logic        sec_serr_s1_reg, sec_serr_s2_reg;
	logic        serr_oe_reg, perr_oe_reg;
	logic        tabort_reg, disc_reg, srst_reg;

	// Address decode
	wire wr_cmd  = cfg_wr && (cfg_addr == `OFF_COMMAND);
	wire wr_sts  = cfg_wr && (cfg_addr == `OFF_STATUS);
	wire wr_brc  = cfg_wr && (cfg_addr == `OFF_BRIDGE_CONTROL);
	wire wr_sctl = cfg_wr && (cfg_addr == `OFF_SERR_CONTROL);
	wire wr_ssts = cfg_wr && (cfg_addr == `OFF_SERR_STATUS);
	wire wr_diag = cfg_wr && (cfg_addr == `OFF_DIAG_CONTROL);

	// Control fields
	wire perr_resp = command_reg[`CMD_PERR_RESP];
	wire serr_en   = command_reg[`CMD_SERR_EN];
	wire long_sel  = diag_control_reg[`DIAG_DISCARD_LONG];

	// =============================================
	// Discard timer
	logic dt_expire, dt_expire_np;

	discard_timer #(
		.LONG_CLKS  (DISCARD_LONG_CLKS),
		.SHORT_CLKS (DISCARD_SHORT_CLKS)
	) u_discard_timer (
		.sys_clk     (sys_clk),
		.nrst        (nrst),
		.start       (dt_complete),
		.nonpref     (!dt_prefetch),
		.retry_match (dt_retry_match),
		.long_sel    (long_sel), // RL15
		.pending     (dt_pending),
		.expire      (dt_expire),
		.expire_np   (dt_expire_np)
	);

	// Prefetchable and nonprefetchable completions both drop on expiry
	assign dt_discard = dt_expire; // RL17 RL16

	// =============================================
	// System-error sources and their gates
	logic [7:0] serr_ev;
	logic [7:0] serr_gate;
	logic [7:0] serr_set;

	assign serr_ev = {retry_expired,
	                  addr_par_err | tgt_abort_rx,
	                  par_err_master,
	                  dt_expire_np,
	                  posted_mabort,
	                  posted_tabort,
	                  posted_perr,
	                  arb_timeout};

	// Control-gated sources also need the command enable; bits 6 and 7 have their own gate
	assign serr_gate[5:0]            = serr_control_reg[5:0] & {6{serr_en}}; // RL18 RL1 RL19
	assign serr_gate[`SERR_ADDR_PERR] = perr_resp;                            // RL3
	assign serr_gate[`SERR_RETRY_TO]  = diag_control_reg[`DIAG_RETRY_TO_EN];   // RL4

	// Per-bit set, and W1C where a same-cycle event beats the clear
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_serr
			assign serr_set[gi]         = serr_ev[gi] & serr_gate[gi];
			assign serr_status_next[gi] = serr_set[gi] |
				(serr_status_reg[gi] & ~(wr_ssts & cfg_wdata[gi]));
		end
	endgenerate

	// Secondary system error, synchronised before use
	wire sec_serr_fwd = !sec_serr_s2_reg && serr_en && bridge_control_reg[`BRC_SERR_FWD]; // RL5
	wire serr_fire    = (|serr_set) || sec_serr_fwd;

	// =============================================
	// Parity status
	wire any_bad_par = data_par_err | addr_par_err | par_err_master;
	wire dpe_set     = perr_resp & (data_par_err | perr_seen_master | par_err_master); // RL10
	wire perr_fire   = perr_resp & data_par_err; // RL8

	// Implemented status bits only; others read zero
	always_comb begin
		status_next = status_reg & ~({16{wr_sts}} & cfg_wdata);
		status_next[`STS_DET_PERR] = status_next[`STS_DET_PERR] | any_bad_par; // RL9
		status_next[`STS_SIG_SERR] = status_next[`STS_SIG_SERR] | serr_fire;   // RL18
		status_next[`STS_DATA_PERR] = status_next[`STS_DATA_PERR] | dpe_set;   // RL10
	end

	// =============================================
	// Read mux
	wire [15:0] rd_mux =
		(cfg_addr == `OFF_COMMAND)        ? command_reg :
		(cfg_addr == `OFF_STATUS)         ? status_reg :
		(cfg_addr == `OFF_BRIDGE_CONTROL) ? bridge_control_reg :
		(cfg_addr == `OFF_SERR_CONTROL)   ? {8'h00, serr_control_reg} :
		(cfg_addr == `OFF_SERR_STATUS)    ? {8'h00, serr_status_reg} :
		(cfg_addr == `OFF_DIAG_CONTROL)   ? diag_control_reg : 16'h0000;

	// =============================================
	// Software-written registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			command_reg        <= `RST_COMMAND;
			bridge_control_reg <= `RST_BRIDGE_CONTROL;
			serr_control_reg   <= `RST_SERR_CONTROL;
			diag_control_reg   <= `RST_DIAG_CONTROL;
		end else begin
			if (wr_cmd)  command_reg        <= cfg_wdata;
			if (wr_brc)  bridge_control_reg <= cfg_wdata;
			if (wr_sctl) serr_control_reg   <= cfg_wdata[7:0];
			if (wr_diag) diag_control_reg   <= cfg_wdata;
		end
	end

	// Status registers and read data
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_reg      <= 16'h0000;
			serr_status_reg <= 8'h00;
			rdata_reg       <= 16'h0000;
		end else begin
			status_reg      <= status_next & 16'hC100;
			serr_status_reg <= serr_status_next; // RL1 RL3 RL4 RL19
			if (cfg_rd) rdata_reg <= rd_mux;
		end
	end

	// Pin synchroniser: the first stage feeds only the second
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sec_serr_s1_reg <= 1'b1;
			sec_serr_s2_reg <= 1'b1;
		end else begin
			sec_serr_s1_reg <= sec_serr_n;
			sec_serr_s2_reg <= sec_serr_s1_reg;
		end
	end

	// =============================================
	// Pin drives and abort responses, one cycle after the cause
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			serr_oe_reg <= 1'b0;
			perr_oe_reg <= 1'b0;
			tabort_reg  <= 1'b0;
			disc_reg    <= 1'b0;
			srst_reg    <= 1'b0;
		end else begin
			serr_oe_reg <= serr_fire;
			perr_oe_reg <= perr_fire;                                          // RL8
			tabort_reg  <= tgt_abort_rx & burst_is_write;                      // RL11
			disc_reg    <= tgt_abort_rx & !burst_is_write;                     // RL12
			srst_reg    <= prim_txn_sec_rst & bridge_control_reg[`BRC_MABORT_MODE]; // RL13
		end
	end

	// Open-drain pins only ever pull low
	assign serr_out        = 1'b0;
	assign serr_oe         = serr_oe_reg;
	assign perr_out        = 1'b0;
	assign perr_oe         = perr_oe_reg;
	assign parity_fix      = diag_control_reg[`DIAG_PARITY_FIX]; // RL6
	assign init_tgt_abort  = tabort_reg;
	assign init_disconnect = disc_reg;
	assign sec_rst_tabort  = srst_reg;
	assign cfg_rdata       = rdata_reg;

	// =============================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	mast_par_serr_a: assert property (par_err_master && serr_control_reg[5] && serr_en && !(wr_sctl || wr_cmd)
		|=> serr_status_reg[5] && serr_oe) else $error("mastering parity not reported"); // RL1
	addr_par_serr_a: assert property ((addr_par_err || tgt_abort_rx) && perr_resp
		|=> serr_status_reg[6] && serr_oe) else $error("address parity not reported"); // RL3
	retry_to_serr_a: assert property (retry_expired && diag_control_reg[15]
		|=> serr_status_reg[7] && serr_oe) else $error("retry timeout not reported"); // RL4
	sec_fwd_gate_a: assert property (serr_oe && !$past(|serr_set)
		|-> $past(serr_en && bridge_control_reg[1])) else $error("secondary error forwarded ungated"); // RL5
	perr_drive_a: assert property (perr_oe |-> $past(data_par_err && perr_resp))
		else $error("PERR without cause"); // RL8
	det_par_a: assert property (any_bad_par |=> status_reg[15]) else $error("bit 15 not set"); // RL9
	dpe_gate_a: assert property ($rose(status_reg[8]) |-> $past(perr_resp))
		else $error("bit 8 set without parity response"); // RL10
	sig_serr_a: assert property (serr_oe |-> status_reg[14]) else $error("bit 14 not set"); // RL18
	abort_split_a: assert property (!(init_tgt_abort && init_disconnect))
		else $error("abort and disconnect together"); // RL11
	w1c_set_wins_a: assert property (wr_ssts && cfg_wdata[6] && serr_set[6] |=> serr_status_reg[6])
		else $error("clear beat a new event"); // RL3
	stop_on_retry_a: assert property (dt_pending && dt_retry_match |=> !dt_pending ##1 !dt_discard)
		else $error("timer kept running after retry"); // RL20
	// Cycles spent armed, counted apart from the timer so that a broken timer counter shows up here
	logic [31:0] armed_cnt_reg;

	// Saturates rather than wraps, so a stuck timer keeps failing the checks below
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			armed_cnt_reg <= 32'h0000_0000;
		end else if (!dt_pending) begin
			armed_cnt_reg <= 32'h0000_0000;
		end else if (armed_cnt_reg != 32'hFFFF_FFFF) begin
			armed_cnt_reg <= armed_cnt_reg + 32'h0000_0001;
		end
	end

	// A limit switched to short mid-count ends the count one cycle later, hence the past term
	short_expire_a: assert property (dt_pending && !long_sel && !$past(long_sel)
		|-> armed_cnt_reg < DISCARD_SHORT_CLKS) else $error("short discard overdue"); // RL15
	long_expire_a: assert property (dt_pending |-> armed_cnt_reg < DISCARD_LONG_CLKS)
		else $error("long discard overdue"); // RL14
	drop_on_expiry_a: assert property ($fell(dt_pending) && !$past(dt_retry_match) |-> dt_discard)
		else $error("timer stopped without discard"); // RL17

	complete_cov_c: cover property ((dt_complete && !dt_pending ##1 dt_pending) ##[1:1000] dt_discard);
	retry_cov_c:    cover property (dt_pending ##1 dt_retry_match);
	serr_cov_c:     cover property (serr_oe && serr_status_reg[4]);
	fwd_cov_c:      cover property (sec_serr_fwd);

endmodule : bridge_error_reporting
`default_nettype wire

// ### verification/pci_agent_model.sv
// Far-side bus agent model that turns a one-cycle request into the matching event pulse
`timescale 1ns/100ps
`default_nettype none
module pci_agent_model (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        ev_go,
	input  wire logic [3:0]  ev_code,
	output logic      [14:0] ev_pulse,
	output logic             sec_serr_n
);
	// =============================================
	// Event pulses
	// Each agent reports an event for exactly one clock; a held level would be read as many events
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ev_pulse <= 15'h0000;
		end else begin
			ev_pulse <= ev_go ? (15'h0001 << ev_code) : 15'h0000;
		end
	end

	// Secondary error pin is active low and rests high on its pull-up between events
	assign sec_serr_n = ~ev_pulse[14];
endmodule : pci_agent_model
`default_nettype wire

// ### verification/bridge_error_reporting_tb_top.sv
// Self-checking bench for the bridge error reporting and discard block
`include "bridge_err_map.svh"
`timescale 1ns/100ps
`default_nettype none
module bridge_error_reporting_tb_top;
	// Short discard limits keep the run brief; expectations follow these values
	localparam int LONG_T  = 64;
	localparam int SHORT_T = 16;
	logic        sys_clk, nrst, cfg_wr, cfg_rd, ev_go, burst_is_write, dt_prefetch, sec_serr_n;
	logic [7:0]  cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [3:0]  ev_code;
	logic [14:0] ev_pulse;
	logic        serr_out, serr_oe, perr_out, perr_oe, parity_fix, init_tgt_abort, init_disconnect;
	logic        sec_rst_tabort, dt_pending, dt_discard;
	logic [5:0]  pv;
	logic [3:0]  src [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
	int          cnt [6] = '{default: 0};
	int          base [6];
	int          n_errors = 0;
	int          check_count = 0;

	// =============================================
	// Design and far-side model
	bridge_error_reporting #(.DISCARD_LONG_CLKS(LONG_T), .DISCARD_SHORT_CLKS(SHORT_T)) bridge_error_reporting_inst (
		.sys_clk(sys_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .arb_timeout(ev_pulse[0]), .posted_perr(ev_pulse[1]),
		.posted_tabort(ev_pulse[2]), .posted_mabort(ev_pulse[3]), .par_err_master(ev_pulse[5]),
		.addr_par_err(ev_pulse[6]), .retry_expired(ev_pulse[7]), .data_par_err(ev_pulse[8]),
		.perr_seen_master(ev_pulse[9]), .tgt_abort_rx(ev_pulse[10]), .burst_is_write(burst_is_write),
		.sec_serr_n(sec_serr_n), .prim_txn_sec_rst(ev_pulse[11]), .dt_complete(ev_pulse[12]),
		.dt_prefetch(dt_prefetch), .dt_retry_match(ev_pulse[13]), .serr_out(serr_out), .serr_oe(serr_oe),
		.perr_out(perr_out), .perr_oe(perr_oe), .parity_fix(parity_fix), .init_tgt_abort(init_tgt_abort),
		.init_disconnect(init_disconnect), .sec_rst_tabort(sec_rst_tabort), .dt_pending(dt_pending),
		.dt_discard(dt_discard));
	pci_agent_model pci_agent_model_inst (.sys_clk(sys_clk), .nrst(nrst), .ev_go(ev_go), .ev_code(ev_code),
		.ev_pulse(ev_pulse), .sec_serr_n(sec_serr_n));

	// =============================================
	// Clock and pulse counters
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Pulses last one cycle, so counting them is safer than sampling them at a guessed edge
	assign pv = {dt_discard, sec_rst_tabort, init_disconnect, init_tgt_abort, perr_oe, serr_oe};
	always @(posedge sys_clk) begin
		for (int i = 0; i < 6; i++) if (pv[i] === 1'b1) cnt[i]++;
	end

	// =============================================
	// Access, stimulus and compare tasks
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int idx, input int exp);
		check_count++;
		if (cnt[idx] - base[idx] != exp) begin
			n_errors++;
			$display("unexpected pulse count at %0t: got %h expected %h", $time, cnt[idx] - base[idx], exp);
		end
	endtask : chk_cnt
	task automatic snap();
		base = cnt;
	endtask : snap
	task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		#1;
	endtask : cfg_write
	task automatic cfg_read_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		cfg_rd   <= 1'b1;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_val(cfg_rdata, exp);
	endtask : cfg_read_chk
	// Returns w cycles after the edge at which the design takes the event
	task automatic fire(input logic [3:0] code, input int w);
		@(posedge sys_clk);
		ev_go   <= 1'b1;
		ev_code <= code;
		@(posedge sys_clk);
		ev_go <= 1'b0;
		repeat (w + 1) @(posedge sys_clk);
		#1;
	endtask : fire
	task automatic discard_run(input int lim, input logic pref, input logic [15:0] exp61);
		int n;
		n = 0;
		@(posedge sys_clk);
		dt_prefetch <= pref;
		fire(4'hC, 0);
		while (n < 200 && dt_discard !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n == 1) chk_val({15'h0000, dt_pending}, 16'h0001);
		end
		// Discard shows up exactly limit edges after the edge that takes the completion
		chk_val(16'(n), 16'(lim));
		repeat (2) @(posedge sys_clk);
		cfg_read_chk(`OFF_SERR_STATUS, exp61);
		cfg_write(`OFF_SERR_STATUS, 16'h00FF);
	endtask : discard_run
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// =============================================
	// Watchdog: the sequence needs about four hundred and fifty cycles, so twenty thousand means a hang
	initial begin
		#(20 * 20000);
		n_errors++;
		close_out();
	end

	// =============================================
	// Test sequence
	initial begin
		{nrst, cfg_wr, cfg_rd, ev_go, burst_is_write, dt_prefetch} = 6'h00;
		{cfg_addr, cfg_wdata, ev_code} = 28'h000_0000;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		// Reset values, unmapped read, parity mode
		cfg_read_chk(`OFF_COMMAND, 16'h0000);
		cfg_read_chk(`OFF_BRIDGE_CONTROL, 16'h0000);
		cfg_read_chk(`OFF_SERR_CONTROL, 16'h0000);
		cfg_read_chk(`OFF_DIAG_CONTROL, 16'h0002);
		cfg_read_chk(8'h10, 16'h0000);
		chk_val({15'h0000, parity_fix}, 16'h0000);
		// Fix parity before the mastering-parity report is enabled
		cfg_write(`OFF_DIAG_CONTROL, 16'hC000);
		chk_val({15'h0000, parity_fix}, 16'h0001);
		cfg_write(`OFF_COMMAND, 16'h0140);
		cfg_write(`OFF_SERR_CONTROL, 16'h00FF);
		// Every reporting source but the discard timer (bit 4): pin, sticky status, write-one clear
		foreach (src[i]) begin
			snap();
			fire(src[i], 2);
			chk_cnt(0, 1);
			cfg_read_chk(`OFF_SERR_STATUS, 16'h0001 << src[i]);
			cfg_write(`OFF_SERR_STATUS, 16'h0001 << src[i]);
			cfg_read_chk(`OFF_SERR_STATUS, 16'h0000);
		end
		cfg_read_chk(`OFF_STATUS, 16'hC100);
		cfg_write(`OFF_STATUS, 16'hFFFF);
		cfg_read_chk(`OFF_STATUS, 16'h0000);
		// Enable gating: command enable off blocks control-gated sources only
		cfg_write(`OFF_COMMAND, 16'h0040);
		snap();
		fire(4'h5, 2);
		fire(4'h7, 2);
		chk_cnt(0, 1);
		cfg_read_chk(`OFF_SERR_STATUS, 16'h0080);
		cfg_write(`OFF_DIAG_CONTROL, 16'h4000);
		cfg_write(`OFF_SERR_STATUS, 16'h00FF);
		fire(4'h7, 2);
		cfg_read_chk(`OFF_SERR_STATUS, 16'h0000);
		// Data parity with and without parity response
		cfg_write(`OFF_STATUS, 16'hFFFF);
		snap();
		fire(4'h8, 2);
		chk_cnt(1, 1);
		cfg_read_chk(`OFF_STATUS, 16'h8100);
		cfg_write(`OFF_STATUS, 16'hFFFF);
		fire(4'h9, 2);
		cfg_read_chk(`OFF_STATUS, 16'h0100);
		cfg_write(`OFF_COMMAND, 16'h0000);
		cfg_write(`OFF_STATUS, 16'hFFFF);
		fire(4'h8, 2);
		chk_cnt(1, 1);
		cfg_read_chk(`OFF_STATUS, 16'h8000);
		// Secondary error forwarding needs both enables
		cfg_write(`OFF_COMMAND, 16'h0100);
		cfg_write(`OFF_STATUS, 16'hFFFF);
		snap();
		fire(4'hE, 4);
		chk_cnt(0, 0);
		cfg_write(`OFF_BRIDGE_CONTROL, 16'h0002);
		fire(4'hE, 4);
		chk_cnt(0, 1);
		cfg_read_chk(`OFF_STATUS, 16'h4000);
		// Target abort on write and read bursts, then with parity response on
		snap();
		@(posedge sys_clk);
		burst_is_write <= 1'b1;
		fire(4'hA, 2);
		@(posedge sys_clk);
		burst_is_write <= 1'b0;
		fire(4'hA, 2);
		chk_cnt(2, 1);
		chk_cnt(3, 1);
		cfg_write(`OFF_COMMAND, 16'h0040);
		fire(4'hA, 2);
		cfg_read_chk(`OFF_SERR_STATUS, 16'h0040);
		cfg_write(`OFF_SERR_STATUS, 16'h00FF);
		// Clear and new address parity event on the same edge: the event must survive
		fork
			fire(4'h6, 2);
			begin
				@(posedge sys_clk);
				cfg_write(`OFF_SERR_STATUS, 16'h0040);
			end
		join
		cfg_read_chk(`OFF_SERR_STATUS, 16'h0040);
		cfg_write(`OFF_SERR_STATUS, 16'h00FF);
		// Primary access during secondary reset follows master abort mode
		fire(4'hB, 2);
		cfg_write(`OFF_BRIDGE_CONTROL, 16'h0022);
		fire(4'hB, 2);
		chk_cnt(4, 1);
		// Discard timer: short nonprefetchable, long prefetchable, then a timely retry
		cfg_write(`OFF_COMMAND, 16'h0100);
		snap();
		discard_run(SHORT_T, 1'b0, 16'h0010);
		cfg_write(`OFF_SERR_CONTROL, 16'h00DF);
		cfg_write(`OFF_DIAG_CONTROL, 16'h0002);
		discard_run(LONG_T, 1'b1, 16'h0000);
		chk_cnt(5, 2);
		fire(4'hC, 4);
		fire(4'hD, 2);
		repeat (LONG_T + 8) @(posedge sys_clk);
		#1;
		chk_cnt(5, 2);
		chk_val({15'h0000, dt_pending}, 16'h0000);
		chk_val({14'h0000, serr_out, perr_out}, 16'h0000);
		close_out();
	end
endmodule : bridge_error_reporting_tb_top
`default_nettype wire
